//--- lltp_map.svh
`ifndef LLTP_MAP_SVH
`define LLTP_MAP_SVH

// ==========================================
// Configuration and transport widths
`define LLTP_ADDR_W 24
`define LLTP_DATA_W 32
`define LLTP_STRB_W 4
`define LLTP_TDATA_W 64
`define LLTP_TKEEP_W 8
`define LLTP_TUSER_W 8

// ==========================================
// Response codes on the configuration ports
`define LLTP_RESP_OK 2'b00
`define LLTP_RESP_ERR 2'b10

// ==========================================
// Sideband bit positions (first beat only) and the full keep mask
`define LLTP_TUSER_RESP_BIT 4
`define LLTP_TUSER_CRIT_BIT 1
`define LLTP_KEEP_ALL 8'hff

// ==========================================
// Controller registers on APB (byte offsets)
`define LLTP_OFS_CFG_ADDR 12'h000
`define LLTP_OFS_CFG_WDATA 12'h004
`define LLTP_OFS_CFG_CTRL 12'h008
`define LLTP_OFS_CFG_STAT 12'h00c
`define LLTP_OFS_CFG_RDATA 12'h010
`define LLTP_OFS_TX_LO 12'h014
`define LLTP_OFS_TX_HI 12'h018
`define LLTP_OFS_TX_CTRL 12'h01c
`define LLTP_OFS_LT_BASE 12'h020

// CFG_CTRL fields
`define LLTP_CTRL_GO_BIT 0
`define LLTP_CTRL_READ_BIT 1
`define LLTP_CTRL_STRB_LSB 4
// CFG_STAT fields
`define LLTP_STAT_BUSY_BIT 0
`define LLTP_STAT_RESP_LSB 1
`define LLTP_STAT_DONE_BIT 3
`define LLTP_STAT_FULL_BIT 4
// TX_CTRL fields
`define LLTP_TXC_KEEP_LSB 0
`define LLTP_TXC_LAST_BIT 8
`define LLTP_TXC_RESP_BIT 9
`define LLTP_TXC_CRIT_BIT 10

// Reset values
`define LLTP_RST_WORD 32'h0000_0000
`define LLTP_RST_STRB 4'hf

`endif

//--- lltp_pkg.sv
package lltp_pkg;
	// Configuration master sequencing
	typedef enum logic [2:0] {
		LLTP_M_IDLE,
		LLTP_M_WRITE,
		LLTP_M_WRESP,
		LLTP_M_READ,
		LLTP_M_RRESP
	} lltp_mstate_e;
	typedef logic [1:0] lltp_resp_t;
endpackage

//--- lltp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lltp_if;
	// Configuration register port: device is the slave
	logic cfgl_awvalid, cfgl_awready;
	logic [23:0] cfgl_awaddr;
	logic cfgl_wvalid, cfgl_wready;
	logic [31:0] cfgl_wdata;
	logic [3:0] cfgl_wstrb;
	logic cfgl_bvalid, cfgl_bready;
	logic cfgl_arvalid, cfgl_arready;
	logic [23:0] cfgl_araddr;
	logic cfgl_rvalid, cfgl_rready;
	logic [31:0] cfgl_rdata;
	// Configuration master port: device is the master
	logic cfgr_awvalid, cfgr_awready;
	logic [23:0] cfgr_awaddr;
	logic [2:0] cfgr_awprot;
	logic cfgr_wvalid, cfgr_wready;
	logic [31:0] cfgr_wdata;
	logic [3:0] cfgr_wstrb;
	logic cfgr_bvalid, cfgr_bready;
	logic [1:0] cfgr_bresp;
	logic cfgr_arvalid, cfgr_arready;
	logic [23:0] cfgr_araddr;
	logic [2:0] cfgr_arprot;
	logic cfgr_rvalid, cfgr_rready;
	logic [1:0] cfgr_rresp;
	logic [31:0] cfgr_rdata;
	// Outbound transport stream
	logic buft_tvalid, buft_tready;
	logic [63:0] buft_tdata;
	logic [7:0] buft_tkeep;
	logic buft_tlast;
	logic [7:0] buft_tuser;

	modport dev (
		input cfgl_awvalid, cfgl_awaddr, cfgl_wvalid, cfgl_wdata, cfgl_wstrb, cfgl_bready,
		input cfgl_arvalid, cfgl_araddr, cfgl_rready,
		output cfgl_awready, cfgl_wready, cfgl_bvalid, cfgl_arready, cfgl_rvalid, cfgl_rdata,
		output cfgr_awvalid, cfgr_awaddr, cfgr_awprot, cfgr_wvalid, cfgr_wdata, cfgr_wstrb,
		output cfgr_bready, cfgr_arvalid, cfgr_araddr, cfgr_arprot, cfgr_rready,
		input cfgr_awready, cfgr_wready, cfgr_bvalid, cfgr_bresp, cfgr_arready,
		input cfgr_rvalid, cfgr_rresp, cfgr_rdata,
		output buft_tvalid, buft_tdata, buft_tkeep, buft_tlast, buft_tuser,
		input buft_tready
	);
	modport fab (
		output cfgl_awvalid, cfgl_awaddr, cfgl_wvalid, cfgl_wdata, cfgl_wstrb, cfgl_bready,
		output cfgl_arvalid, cfgl_araddr, cfgl_rready,
		input cfgl_awready, cfgl_wready, cfgl_bvalid, cfgl_arready, cfgl_rvalid, cfgl_rdata,
		input cfgr_awvalid, cfgr_awaddr, cfgr_awprot, cfgr_wvalid, cfgr_wdata, cfgr_wstrb,
		input cfgr_bready, cfgr_arvalid, cfgr_araddr, cfgr_arprot, cfgr_rready,
		output cfgr_awready, cfgr_wready, cfgr_bvalid, cfgr_bresp, cfgr_arready,
		output cfgr_rvalid, cfgr_rresp, cfgr_rdata,
		input buft_tvalid, buft_tdata, buft_tkeep, buft_tlast, buft_tuser,
		output buft_tready
	);
endinterface
`default_nettype wire

//--- lltp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module lltp_fifo #(
	parameter int WIDTH = 81,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// ==========================================
	// Parameter check
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
			$error("lltp_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push, pop;

	// Honest flags straight from the fill count
	assign in_ready = count_reg < (AW+1)'(DEPTH);
	assign out_valid = (count_reg != '0);
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;
	// Storage is flops, so the head word is muxed out combinationally by rd_ptr_reg
	assign out_data = mem[rd_ptr_reg];

	// ==========================================
	// Storage, no reset needed on data
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- lltp_log.sv
// How it works
// R1: Master port issues local config reads, writes
// R2: Slave port services logical/transport registers
// R3: Each channel transfers on valid and ready
// R4: Config addresses are 24-bit offsets
// R5: Write data 32 bits, 4-bit byte strobe
// R6: Fabric answers 00 ok, 10 error
// R7: Read data returned with read valid
// R8: Write done when response taken
// R9: Stream feeds buffer or physical_layer
// R10: Stream carries packets on 64 bits
// R11: Last marker on final packet beat
// R12: Byte-valid all ones except last beat
// R13: Keep bit 7 covers top byte
// R14: First-beat sideband bit 4 marks response
// R15: First-beat bit 1 critical flag, rest zero
// R16: Slave port always completes without error
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lltp_map.svh"
module lltp_log
	import lltp_pkg::*;
#(
	parameter int LT_WORDS = 4,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	lltp_if.dev link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int LW = $clog2(LT_WORDS);
	localparam int FW = `LLTP_TDATA_W + `LLTP_TKEEP_W + 1 + `LLTP_TUSER_W;

	generate
		if (LT_WORDS < 2 || LT_WORDS > 8 || (LT_WORDS & (LT_WORDS - 1)) != 0) begin : g_bad
			$error("lltp_log: LT_WORDS must be a power of two, 2 to 8");
		end
	endgenerate

	// ==========================================
	// APB decode
	logic apb_acc, apb_wr, tx_push_req, fifo_in_ready, lt_hit;
	assign apb_acc = ce && psel && penable;
	assign apb_wr = apb_acc && pwrite && pready;
	assign tx_push_req = apb_acc && pwrite && (paddr == `LLTP_OFS_TX_CTRL);
	// Back-pressure: a push waits in its access phase while the FIFO is full
	assign pready = !(tx_push_req && !fifo_in_ready);
	assign lt_hit = (paddr >= `LLTP_OFS_LT_BASE) && (paddr < `LLTP_OFS_LT_BASE + 12'(4 * LT_WORDS));
	assign pslverr = apb_acc && !(paddr[1:0] == 2'b00 && (paddr <= `LLTP_OFS_TX_CTRL || lt_hit));

	// ==========================================
	// Controller registers
	logic [23:0] cfg_addr_reg;
	logic [31:0] cfg_wdata_reg, cfg_rdata_reg, tx_lo_reg, tx_hi_reg;
	logic [3:0] cfg_strb_reg;
	logic cfg_read_reg, cfg_done_reg, go;
	lltp_resp_t cfg_resp_reg;
	lltp_mstate_e mst_reg;
	logic [31:0] lt_regs [LT_WORDS];

	assign go = apb_wr && paddr == `LLTP_OFS_CFG_CTRL && pwdata[`LLTP_CTRL_GO_BIT] && mst_reg == LLTP_M_IDLE;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg_addr_reg <= '0;
			cfg_wdata_reg <= `LLTP_RST_WORD;
			cfg_strb_reg <= `LLTP_RST_STRB;
			cfg_read_reg <= 1'b0;
			tx_lo_reg <= `LLTP_RST_WORD;
			tx_hi_reg <= `LLTP_RST_WORD;
		end else if (apb_wr) begin
			case (paddr)
				`LLTP_OFS_CFG_ADDR: cfg_addr_reg <= pwdata[23:0]; // see R4
				`LLTP_OFS_CFG_WDATA: cfg_wdata_reg <= pwdata;
				`LLTP_OFS_CFG_CTRL: begin
					// Order fields are frozen while a transfer is running
					if (mst_reg == LLTP_M_IDLE) begin
						cfg_read_reg <= pwdata[`LLTP_CTRL_READ_BIT];
						cfg_strb_reg <= pwdata[`LLTP_CTRL_STRB_LSB +: 4]; // see R5
					end
				end
				`LLTP_OFS_TX_LO: tx_lo_reg <= pwdata;
				`LLTP_OFS_TX_HI: tx_hi_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// APB read mux, zero on unmapped
	always_comb begin
		prdata = '0;
		case (paddr)
			`LLTP_OFS_CFG_ADDR: prdata = {8'h00, cfg_addr_reg};
			`LLTP_OFS_CFG_WDATA: prdata = cfg_wdata_reg;
			`LLTP_OFS_CFG_CTRL: prdata = {24'h0, cfg_strb_reg, 2'b00, cfg_read_reg, 1'b0};
			`LLTP_OFS_CFG_STAT: prdata = {27'h0, !fifo_in_ready, cfg_done_reg, cfg_resp_reg, mst_reg != LLTP_M_IDLE};
			`LLTP_OFS_CFG_RDATA: prdata = cfg_rdata_reg;
			`LLTP_OFS_TX_LO: prdata = tx_lo_reg;
			`LLTP_OFS_TX_HI: prdata = tx_hi_reg;
			default: begin
				if (lt_hit) begin
					prdata = lt_regs[paddr[LW+1:2]];
				end
			end
		endcase
	end

	// ==========================================
	// Configuration master sequencer
	logic aw_sent_reg, w_sent_reg;
	assign link.cfgr_awprot = 3'b000;
	assign link.cfgr_arprot = 3'b000;
	assign link.cfgr_awaddr = cfg_addr_reg;
	assign link.cfgr_araddr = cfg_addr_reg;
	assign link.cfgr_wdata = cfg_wdata_reg;
	assign link.cfgr_wstrb = cfg_strb_reg;
	// Address and data go out independently; each drops once taken
	assign link.cfgr_awvalid = (mst_reg == LLTP_M_WRITE) && !aw_sent_reg; // see R1
	assign link.cfgr_wvalid = (mst_reg == LLTP_M_WRITE) && !w_sent_reg;
	assign link.cfgr_bready = (mst_reg == LLTP_M_WRESP);
	assign link.cfgr_arvalid = (mst_reg == LLTP_M_READ); // see R1
	assign link.cfgr_rready = (mst_reg == LLTP_M_RRESP);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mst_reg <= LLTP_M_IDLE;
			aw_sent_reg <= 1'b0;
			w_sent_reg <= 1'b0;
			cfg_resp_reg <= `LLTP_RESP_OK;
			cfg_rdata_reg <= `LLTP_RST_WORD;
			cfg_done_reg <= 1'b0;
		end else if (ce) begin
			case (mst_reg)
				LLTP_M_IDLE: begin
					if (go) begin
						mst_reg <= pwdata[`LLTP_CTRL_READ_BIT] ? LLTP_M_READ : LLTP_M_WRITE;
						cfg_done_reg <= 1'b0;
					end
				end
				LLTP_M_WRITE: begin
					// see R3
					if (link.cfgr_awready) begin
						aw_sent_reg <= 1'b1;
					end
					if (link.cfgr_wready) begin
						w_sent_reg <= 1'b1;
					end
					if ((aw_sent_reg || link.cfgr_awready) && (w_sent_reg || link.cfgr_wready)) begin
						mst_reg <= LLTP_M_WRESP;
					end
				end
				LLTP_M_WRESP: begin
					if (link.cfgr_bvalid) begin // see R8
						cfg_resp_reg <= link.cfgr_bresp; // see R6
						cfg_done_reg <= 1'b1;
						aw_sent_reg <= 1'b0;
						w_sent_reg <= 1'b0;
						mst_reg <= LLTP_M_IDLE;
					end
				end
				LLTP_M_READ: begin
					if (link.cfgr_arready) begin
						mst_reg <= LLTP_M_RRESP;
					end
				end
				LLTP_M_RRESP: begin
					if (link.cfgr_rvalid) begin
						cfg_rdata_reg <= link.cfgr_rdata; // see R7
						cfg_resp_reg <= link.cfgr_rresp; // see R6
						cfg_done_reg <= 1'b1;
						mst_reg <= LLTP_M_IDLE;
					end
				end
				default: mst_reg <= LLTP_M_IDLE;
			endcase
		end
	end

	// ==========================================
	// Configuration register slave
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [23:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	assign link.cfgl_awready = !aw_held_reg; // see R2
	assign link.cfgl_wready = !w_held_reg;
	assign link.cfgl_arready = !rvalid_reg;
	assign link.cfgl_bvalid = bvalid_reg;
	assign link.cfgl_rvalid = rvalid_reg;
	assign link.cfgl_rdata = rdata_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			for (int i = 0; i < LT_WORDS; i++) begin
				lt_regs[i] <= `LLTP_RST_WORD;
			end
		end else if (ce) begin
			if (link.cfgl_awvalid && !aw_held_reg) begin // see R3
				aw_held_reg <= 1'b1;
				aw_addr_reg <= link.cfgl_awaddr; // see R4
			end
			if (link.cfgl_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				w_data_reg <= link.cfgl_wdata;
				w_strb_reg <= link.cfgl_wstrb;
			end
			// Commit once both halves are held and the last answer is gone
			if (aw_held_reg && w_held_reg && !bvalid_reg) begin
				if (aw_addr_reg[23:LW+2] == '0) begin
					for (int b = 0; b < 4; b++) begin
						if (w_strb_reg[b]) begin // see R5
							lt_regs[aw_addr_reg[LW+1:2]][8*b +: 8] <= w_data_reg[8*b +: 8];
						end
					end
				end
				bvalid_reg <= 1'b1; // see R16
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
			if (bvalid_reg && link.cfgl_bready) begin // see R8
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read side; out-of-range offsets read zero, still completed
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
		end else if (ce) begin
			if (link.cfgl_arvalid && !rvalid_reg) begin
				rvalid_reg <= 1'b1; // see R16
				rdata_reg <= (link.cfgl_araddr[23:LW+2] == '0) ? lt_regs[link.cfgl_araddr[LW+1:2]] : '0; // see R7
			end else if (rvalid_reg && link.cfgl_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Outbound stream: beats built at push time, queued in the FIFO
	logic first_beat_reg, push;
	logic [7:0] beat_keep, beat_user;
	logic beat_last;
	logic [FW-1:0] fifo_out;
	assign push = apb_wr && paddr == `LLTP_OFS_TX_CTRL;
	assign beat_last = pwdata[`LLTP_TXC_LAST_BIT];
	// Keep is forced full except on the packet's closing beat
	assign beat_keep = beat_last ? pwdata[`LLTP_TXC_KEEP_LSB +: 8] : `LLTP_KEEP_ALL; // see R12

	// Sideband only meaningful on the first beat; later beats carry zero
	always_comb begin
		beat_user = '0;
		if (first_beat_reg) begin
			beat_user[`LLTP_TUSER_RESP_BIT] = pwdata[`LLTP_TXC_RESP_BIT]; // see R14
			beat_user[`LLTP_TUSER_CRIT_BIT] = pwdata[`LLTP_TXC_CRIT_BIT]; // see R15
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			first_beat_reg <= 1'b1;
		end else if (push) begin
			first_beat_reg <= beat_last; // see R11
		end
	end

	lltp_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_txq (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({tx_hi_reg, tx_lo_reg, beat_keep, beat_last, beat_user}),
		.out_valid(link.buft_tvalid),
		.out_ready(link.buft_tready),
		.out_data(fifo_out)
	);

	// Word bytes map straight: keep bit n covers tdata[8n+7:8n]; see R13
	assign link.buft_tdata = fifo_out[FW-1 -: 64]; // see R10, R9
	assign link.buft_tkeep = fifo_out[16:9];
	assign link.buft_tlast = fifo_out[8];
	assign link.buft_tuser = fifo_out[7:0];
endmodule
`default_nettype wire

//--- lltp_fab.sv
`timescale 1ns/1ps
`default_nettype none
`include "lltp_map.svh"
module lltp_fab
	import lltp_pkg::*;
#(
	parameter int CFG_WORDS = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	lltp_if.fab link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [23:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_strb,
	output logic ans_valid,
	output logic [31:0] ans_rdata,
	output logic snk_valid,
	input wire logic snk_ready,
	output logic [63:0] snk_data,
	output logic [7:0] snk_keep,
	output logic snk_last,
	output logic [7:0] snk_user
);
	localparam int CW = $clog2(CFG_WORDS);
	generate
		if (CFG_WORDS < 2 || (CFG_WORDS & (CFG_WORDS - 1)) != 0) begin : g_bad
			$error("lltp_fab: CFG_WORDS must be a power of two >= 2");
		end
	endgenerate

	// ==========================================
	// Local configuration space served to the master port
	logic [31:0] cfg_mem [CFG_WORDS];
	logic aw_h_reg, w_h_reg, bv_reg, rv_reg;
	logic [23:0] aw_a_reg;
	logic [31:0] w_d_reg, rd_reg;
	logic [3:0] w_s_reg;
	lltp_resp_t bresp_reg, rresp_reg;
	assign link.cfgr_awready = !aw_h_reg;
	assign link.cfgr_wready = !w_h_reg;
	assign link.cfgr_arready = !rv_reg;
	assign link.cfgr_bvalid = bv_reg;
	assign link.cfgr_bresp = bresp_reg;
	assign link.cfgr_rvalid = rv_reg;
	assign link.cfgr_rresp = rresp_reg;
	assign link.cfgr_rdata = rd_reg;

	// Offsets past the space answer with the error code
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			aw_h_reg <= 1'b0;
			w_h_reg <= 1'b0;
			bv_reg <= 1'b0;
			rv_reg <= 1'b0;
			aw_a_reg <= '0;
			w_d_reg <= '0;
			w_s_reg <= '0;
			rd_reg <= '0;
			bresp_reg <= `LLTP_RESP_OK;
			rresp_reg <= `LLTP_RESP_OK;
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg_mem[i] <= `LLTP_RST_WORD;
			end
		end else if (ce) begin
			if (link.cfgr_awvalid && !aw_h_reg) begin // see R3
				aw_h_reg <= 1'b1;
				aw_a_reg <= link.cfgr_awaddr;
			end
			if (link.cfgr_wvalid && !w_h_reg) begin
				w_h_reg <= 1'b1;
				w_d_reg <= link.cfgr_wdata;
				w_s_reg <= link.cfgr_wstrb;
			end
			if (aw_h_reg && w_h_reg && !bv_reg) begin
				if (aw_a_reg[23:CW+2] == '0) begin
					for (int b = 0; b < 4; b++) begin
						if (w_s_reg[b]) begin // see R5
							cfg_mem[aw_a_reg[CW+1:2]][8*b +: 8] <= w_d_reg[8*b +: 8];
						end
					end
				end
				bresp_reg <= (aw_a_reg[23:CW+2] == '0) ? `LLTP_RESP_OK : `LLTP_RESP_ERR; // see R6
				bv_reg <= 1'b1;
				aw_h_reg <= 1'b0;
				w_h_reg <= 1'b0;
			end
			if (bv_reg && link.cfgr_bready) begin // see R8
				bv_reg <= 1'b0;
			end
			if (link.cfgr_arvalid && !rv_reg) begin // see R4
				rv_reg <= 1'b1;
				rd_reg <= (link.cfgr_araddr[23:CW+2] == '0) ? cfg_mem[link.cfgr_araddr[CW+1:2]] : '0; // see R7
				rresp_reg <= (link.cfgr_araddr[23:CW+2] == '0) ? `LLTP_RESP_OK : `LLTP_RESP_ERR; // see R6
			end else if (rv_reg && link.cfgr_rready) begin
				rv_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Initiator to the register slave, one order at a time
	logic busy_reg, wr_reg, aw_v_reg, w_v_reg, ar_v_reg;
	logic [23:0] addr_reg;
	logic [31:0] wd_reg;
	logic [3:0] st_reg;
	assign req_ready = !busy_reg;
	assign link.cfgl_awvalid = aw_v_reg;
	assign link.cfgl_wvalid = w_v_reg;
	assign link.cfgl_arvalid = ar_v_reg;
	assign link.cfgl_awaddr = addr_reg;
	assign link.cfgl_araddr = addr_reg;
	assign link.cfgl_wdata = wd_reg;
	assign link.cfgl_wstrb = st_reg;
	assign link.cfgl_bready = busy_reg && wr_reg;
	assign link.cfgl_rready = busy_reg && !wr_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			wr_reg <= 1'b0;
			aw_v_reg <= 1'b0;
			w_v_reg <= 1'b0;
			ar_v_reg <= 1'b0;
			addr_reg <= '0;
			wd_reg <= '0;
			st_reg <= '0;
			ans_valid <= 1'b0;
			ans_rdata <= '0;
		end else if (ce) begin
			ans_valid <= 1'b0;
			if (!busy_reg && req_valid) begin
				busy_reg <= 1'b1;
				wr_reg <= req_write;
				addr_reg <= req_addr; // see R4
				wd_reg <= req_wdata;
				st_reg <= req_strb;
				aw_v_reg <= req_write;
				w_v_reg <= req_write;
				ar_v_reg <= !req_write;
			end else if (busy_reg) begin
				if (link.cfgl_awready) begin // see R3
					aw_v_reg <= 1'b0;
				end
				if (link.cfgl_wready) begin
					w_v_reg <= 1'b0;
				end
				if (link.cfgl_arready) begin
					ar_v_reg <= 1'b0;
				end
				if ((wr_reg && link.cfgl_bvalid) || (!wr_reg && link.cfgl_rvalid)) begin // see R8
					busy_reg <= 1'b0;
					ans_valid <= 1'b1;
					ans_rdata <= wr_reg ? '0 : link.cfgl_rdata; // see R7
				end
			end
		end
	end

	// ==========================================
	// Stream sink: one register stage, stalls when the user holds off
	logic hv_reg;
	assign link.buft_tready = !hv_reg || snk_ready; // see R9
	assign snk_valid = hv_reg;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hv_reg <= 1'b0;
			snk_data <= '0;
			snk_keep <= '0;
			snk_last <= 1'b0;
			snk_user <= '0;
		end else if (ce) begin
			if (link.buft_tvalid && link.buft_tready) begin
				hv_reg <= 1'b1;
				snk_data <= link.buft_tdata;
				snk_keep <= link.buft_tkeep;
				snk_last <= link.buft_tlast;
				snk_user <= link.buft_tuser;
			end else if (snk_ready) begin
				hv_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- lltp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lltp_monitor (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cfgr_awvalid,
	input wire logic cfgr_awready,
	input wire logic [23:0] cfgr_awaddr,
	input wire logic [2:0] cfgr_awprot,
	input wire logic cfgr_wvalid,
	input wire logic cfgr_wready,
	input wire logic [31:0] cfgr_wdata,
	input wire logic cfgl_arvalid,
	input wire logic cfgl_arready,
	input wire logic cfgl_rvalid,
	input wire logic buft_tvalid,
	input wire logic buft_tready,
	input wire logic [63:0] buft_tdata,
	input wire logic [7:0] buft_tkeep,
	input wire logic buft_tlast,
	input wire logic [7:0] buft_tuser
);
	// ==========================================
	// Packet framing tracker
	logic first_reg;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) first_reg <= 1'b1;
		else if (buft_tvalid && buft_tready) first_reg <= buft_tlast;
	end

	// ==========================================
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_aw_wait;
		cfgr_awvalid && !cfgr_awready;
	endsequence
	sequence s_w_wait;
		cfgr_wvalid && !cfgr_wready;
	endsequence
	a_aw_hold: assert property (s_aw_wait |=> cfgr_awvalid && $stable(cfgr_awaddr))
		else $error("address withdrawn");
	a_w_hold: assert property (s_w_wait |=> cfgr_wvalid && $stable(cfgr_wdata))
		else $error("write data withdrawn");
	a_prot_zero: assert property (cfgr_awvalid |-> cfgr_awprot == 3'h0)
		else $error("prot not zero");
	a_rd_answer: assert property (cfgl_arvalid && cfgl_arready |=> cfgl_rvalid)
		else $error("read data late");
	a_keep_full: assert property (buft_tvalid && !buft_tlast |-> buft_tkeep == 8'hff)
		else $error("keep not full");
	a_beat_hold: assert property (buft_tvalid && !buft_tready |=> buft_tvalid && $stable(buft_tdata))
		else $error("beat withdrawn");
	a_user_bits: assert property (buft_tvalid |-> (buft_tuser & 8'hed) == 8'h00)
		else $error("reserved sideband set");
	a_user_later: assert property (buft_tvalid && !first_reg |-> buft_tuser == 8'h00)
		else $error("sideband on later beat");
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0, reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, ans_rdata;
	logic req_valid = 1'b0, req_ready, req_write = 1'b0, ans_valid;
	logic [23:0] req_addr = 24'h0;
	logic [31:0] req_wdata = 32'h0;
	logic [3:0] req_strb = 4'hf;
	logic snk_valid, snk_ready = 1'b1, snk_last;
	logic [63:0] snk_data;
	logic [7:0] snk_keep, snk_user;
	int n_errors = 0, num_checks = 0, cycles = 0;

	// ==========================================
	// Design under test, both ends
	lltp_if link();
	lltp_log u_lltp_log (.clk_sys, .reset, .ce(1'b1), .link(link.dev), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	lltp_fab u_lltp_fab (.clk_sys, .reset, .ce(1'b1), .link(link.fab), .req_valid, .req_ready, .req_write,
		.req_addr, .req_wdata, .req_strb, .ans_valid, .ans_rdata, .snk_valid, .snk_ready, .snk_data,
		.snk_keep, .snk_last, .snk_user);
	lltp_monitor u_lltp_monitor (.clk_sys, .reset, .cfgr_awvalid(link.cfgr_awvalid),
		.cfgr_awready(link.cfgr_awready), .cfgr_awaddr(link.cfgr_awaddr), .cfgr_awprot(link.cfgr_awprot),
		.cfgr_wvalid(link.cfgr_wvalid), .cfgr_wready(link.cfgr_wready), .cfgr_wdata(link.cfgr_wdata),
		.cfgl_arvalid(link.cfgl_arvalid), .cfgl_arready(link.cfgl_arready), .cfgl_rvalid(link.cfgl_rvalid),
		.buft_tvalid(link.buft_tvalid), .buft_tready(link.buft_tready), .buft_tdata(link.buft_tdata),
		.buft_tkeep(link.buft_tkeep), .buft_tlast(link.buft_tlast), .buft_tuser(link.buft_tuser));

	// Clock and watchdog; a hang counts as a mismatch
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	// ==========================================
	// Shared tasks
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// APB transfer; pready and read data taken at one rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_done(output logic [31:0] r);
		do apb(1'b0, 12'h00c, 32'h0, r); while (r[3] !== 1'b1);
	endtask
	// One order to the register slave, then its answer
	task automatic fab(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge clk_sys); while (ans_valid !== 1'b1);
		r = ans_rdata;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_cfg_master();
		logic [31:0] r;
		logic [23:0] ad[3] = '{24'h8, 24'h8, 24'h40};
		logic [31:0] wd[3] = '{32'h1234_5678, 32'hffff_ffff, 32'h0};
		logic [31:0] ct[3] = '{32'hf1, 32'h31, 32'hf1};
		logic [31:0] rd[3] = '{32'h1234_5678, 32'h1234_ffff, 32'h0};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h000, 32'(ad[i]), r);
			apb(1'b1, 12'h004, wd[i], r);
			apb(1'b1, 12'h008, ct[i], r);
			wait_done(r);
			check("write resp", r[2:1], (i == 2) ? 2'b10 : 2'b00);
			apb(1'b1, 12'h008, 32'hf3, r);
			wait_done(r);
			check("read resp", r[2:1], (i == 2) ? 2'b10 : 2'b00);
			apb(1'b0, 12'h010, 32'h0, r);
			check("read data", r, rd[i]);
		end
	endtask
	task automatic t_cfg_slave();
		logic [31:0] r;
		fab(1'b1, 24'h4, 32'habcd_0123, r);
		fab(1'b0, 24'h4, 32'h0, r);
		check("slave read", r, 32'habcd_0123);
		apb(1'b0, 12'h024, 32'h0, r);
		check("slave view", r, 32'habcd_0123);
		fab(1'b1, 24'h100, 32'hffff_ffff, r);
		fab(1'b0, 24'h100, 32'h0, r);
		check("slave far", r, 32'h0);
	endtask
	// Nine beats with the sink stalled: one held, eight fill the buffer
	task automatic t_stream();
		logic [31:0] r;
		snk_ready <= 1'b0;
		fork
			begin
				for (int i = 0; i < 9; i++) begin
					apb(1'b1, 12'h014, 32'(i), r);
					apb(1'b1, 12'h018, 32'hbeef_0000, r);
					apb(1'b1, 12'h01c, (i == 8) ? 32'h10f : (i == 0) ? 32'h600 : 32'h0, r);
				end
				apb(1'b0, 12'h00c, 32'h0, r);
				check("fifo full", r[4], 1'b1);
				snk_ready <= 1'b1;
			end
			for (int k = 0; k < 9; k++) begin
				do @(posedge clk_sys); while ((link.buft_tvalid && link.buft_tready) !== 1'b1);
				check("tdata", link.buft_tdata, {32'hbeef_0000, 32'(k)});
				check("tkeep", link.buft_tkeep, (k == 8) ? 8'h0f : 8'hff);
				check("tlast", link.buft_tlast, k == 8);
				check("tuser", link.buft_tuser, (k == 0) ? 8'h12 : 8'h00);
			end
		join
		repeat (12) @(posedge clk_sys);
		check("drained", link.buft_tvalid, 1'b0);
		check("sink tail", {snk_valid, snk_last, snk_keep, snk_data[7:0]}, {1'b0, 1'b1, 8'h0f, 8'h08});
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		t_cfg_master();
		t_cfg_slave();
		t_stream();
		give_verdict();
	end
endmodule
`default_nettype wire
